/* logic/flash_cycle_timer.sv */
// Down-counting cycle timer with a one-cycle done pulse
`timescale 1ns/1ns
module flash_cycle_timer #(
  parameter int W          = flash_seq_pkg::TMR_W,
  parameter int INIT_COUNT = 0
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          load,
  input  wire logic [W-1:0]  load_val,
  output logic               busy,
  output logic               done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } tmr_state_type;

  localparam tmr_state_type RESET_VALUE = '{cnt: W'(INIT_COUNT), busy: (INIT_COUNT != 0), done: 1'b0};

  tmr_state_type s_q;
  tmr_state_type s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (load) begin
      s_d.cnt  = load_val;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      s_d.cnt = s_q.cnt - W'(1);
      if (s_q.cnt <= W'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= RESET_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule // flash_cycle_timer

/* logic/flash_self_erase_write_sequencer.sv */
// Flash self erase/write sequencer with AHB-Lite register slave
// Notes on behaviour
// - Erase always clears one 32-word row
// - Row from upper 11 address bits; 4:0 ignored
// - Erase needs space select, permit, erase select
// - Start only after 55h then AAh unlock
// - Erase: two setup cycles, two instructions ignored
// - Erase stalls CPU about 2 ms
// - Writes into protected regions are refused
// - Writes cover aligned four-word blocks only
// - Four 14-bit buffers selected by address 1:0
// - Short write buffers word, go clears next cycle
// - Long write: execute one, ignore one, stall
// - Buffers reset to 3FFF after long write
// - Permit cleared at reset; power-up timer blocks writes
// - Data code-protect blocks all external access
// - Program code-protect blocks external program writes only
// - Erase or long-write completion clears go and sets done flag; short write clears go only
// - Go cannot set without permit already set
// - Space select bit 7, fetch bit 0
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module flash_self_erase_write_sequencer #(
  parameter int          ERASE_CYCLES     = flash_seq_pkg::ERASE_CYCLES,
  parameter int          WRITE_CYCLES     = flash_seq_pkg::WRITE_CYCLES,
  parameter int          PWRT_CYCLES      = flash_seq_pkg::PWRT_CYCLES,
  parameter logic [15:0] PROT_LIMIT_SMALL = 16'h0100,
  parameter logic [15:0] PROT_LIMIT_MID   = 16'h0800,
  parameter logic [15:0] PROT_LIMIT_ALL   = 16'h1000
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [11:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic [1:0]   cfg_self_protect,
  input  wire logic         cfg_code_protect_prog,
  input  wire logic         cfg_code_protect_data,
  input  wire logic         ext_prog_write_req,
  input  wire logic         ext_ee_access_req,
  output logic              ext_prog_write_allow,
  output logic              ext_ee_access_allow,
  output logic              cpu_stall,
  output logic              insn_ignore,
  output logic              flash_erase_start,
  output logic              flash_write_start,
  output logic      [15:0]  flash_addr,
  output logic      [55:0]  flash_wdata
);

  typedef struct packed {
    flash_seq_pkg::seq_state_type    seq;
    flash_seq_pkg::unlock_state_type ul;
    logic [7:0]  addr_low;
    logic [7:0]  addr_high;
    logic [7:0]  data_low;
    logic [5:0]  data_high;
    logic        pss;
    logic        erase_sel;
    logic        err;
    logic        permit;
    logic        go;
    logic        fetch_go;
    logic        done;
    logic        op_erase;
    logic        short_wr;
    logic        erase_start;
    logic        write_start;
    logic [15:0] flash_addr;
    logic        ph_valid;
    logic [9:0]  ph_index;
    logic [31:0] rdata;
  } seq_regs_type;

  localparam seq_regs_type RESET_VALUE = '0;

  seq_regs_type              s_q;
  seq_regs_type              s_d;
  logic                      buf_load;
  logic                      buf_clear;
  logic                      tmr_load;
  logic [flash_seq_pkg::TMR_W-1:0] tmr_val;
  logic                      tmr_done;
  logic                      pwrt_busy;
  logic [15:0]               cur_addr;
  logic                      start_ok;
  logic                      wr_data;

  function automatic logic is_protected(input logic [1:0] f, input logic [15:0] a);
    case (f)
      flash_seq_pkg::PROT_NONE:  is_protected = 1'b0;
      flash_seq_pkg::PROT_SMALL: is_protected = (a < PROT_LIMIT_SMALL);
      flash_seq_pkg::PROT_MID:   is_protected = (a < PROT_LIMIT_MID);
      default:                   is_protected = (a < PROT_LIMIT_ALL);
    endcase
  endfunction

  // ****************************************
  // Sub-blocks
  // ****************************************
  flash_word_buffer u_buf (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (buf_load),
    .sel     (s_q.addr_low[1:0]),
    .wdata   ({s_q.data_high, s_q.data_low}),
    .clear   (buf_clear),
    .words   (flash_wdata)
  );

  flash_cycle_timer u_stall_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (),
    .done     (tmr_done)
  );

  flash_cycle_timer #(.INIT_COUNT(PWRT_CYCLES)) u_pwrt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (1'b0),
    .load_val ('0),
    .busy     (pwrt_busy),
    .done     ()
  );

  assign cur_addr = {s_q.addr_high, s_q.addr_low};
  assign wr_data  = s_q.ph_valid;

  // ****************************************
  // Register file and sequencer
  // ****************************************
  always_comb begin
    s_d         = s_q;
    buf_load    = 1'b0;
    buf_clear   = 1'b0;
    tmr_load    = 1'b0;
    tmr_val     = flash_seq_pkg::TMR_W'(WRITE_CYCLES);
    start_ok    = 1'b0;
    s_d.erase_start = 1'b0;
    s_d.write_start = 1'b0;
    s_d.fetch_go    = 1'b0;
    // Address phase, write-only word transfers are latched for the data phase
    s_d.ph_valid = hsel && hready && htrans[1] && hwrite && (hsize == flash_seq_pkg::HSIZE_WORD);
    s_d.ph_index = haddr[11:2];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[11:2])
        flash_seq_pkg::IDX_DATA_LOW:  s_d.rdata = {24'h0, s_q.data_low};
        flash_seq_pkg::IDX_ADDR_LOW:  s_d.rdata = {24'h0, s_q.addr_low};
        flash_seq_pkg::IDX_DATA_HIGH: s_d.rdata = {26'h0, s_q.data_high};
        flash_seq_pkg::IDX_ADDR_HIGH: s_d.rdata = {24'h0, s_q.addr_high};
        flash_seq_pkg::IDX_MEM_CTRL:  s_d.rdata = {24'h0, s_q.pss, 2'b00, s_q.erase_sel, s_q.err,
                                                   s_q.permit, s_q.go, s_q.fetch_go};
        flash_seq_pkg::IDX_DONE:      s_d.rdata = {27'h0, s_q.done, 4'h0};
        flash_seq_pkg::IDX_STATUS:    s_d.rdata = {26'h0, cfg_code_protect_data, cfg_code_protect_prog,
                                                   cfg_self_protect, pwrt_busy, s_q.go};
        default:                      s_d.rdata = 32'h0;
      endcase
    end
    // Data phase writes
    if (wr_data) begin
      if (s_q.ph_index != flash_seq_pkg::IDX_UNLOCK) begin
        s_d.ul = flash_seq_pkg::UL_NONE;
      end
      case (s_q.ph_index)
        flash_seq_pkg::IDX_DATA_LOW:  s_d.data_low  = hwdata[7:0];
        flash_seq_pkg::IDX_ADDR_LOW:  s_d.addr_low  = hwdata[7:0];
        flash_seq_pkg::IDX_DATA_HIGH: s_d.data_high = hwdata[5:0];
        flash_seq_pkg::IDX_ADDR_HIGH: s_d.addr_high = hwdata[7:0];
        flash_seq_pkg::IDX_DONE:      s_d.done      = hwdata[flash_seq_pkg::DONE_BIT];
        flash_seq_pkg::IDX_UNLOCK: begin
          if (hwdata[7:0] == flash_seq_pkg::UNLOCK_FIRST) begin
            s_d.ul = flash_seq_pkg::UL_FIRST;
          end else if ((hwdata[7:0] == flash_seq_pkg::UNLOCK_SECOND) && (s_q.ul == flash_seq_pkg::UL_FIRST)) begin
            s_d.ul = flash_seq_pkg::UL_ARMED;
          end else begin
            s_d.ul = flash_seq_pkg::UL_NONE;
          end
        end
        flash_seq_pkg::IDX_MEM_CTRL: begin
          s_d.pss       = hwdata[flash_seq_pkg::MC_PSS_BIT];
          s_d.erase_sel = hwdata[flash_seq_pkg::MC_ERASE_BIT];
          s_d.permit    = hwdata[flash_seq_pkg::MC_PERMIT_BIT];
          s_d.err       = s_q.err & hwdata[flash_seq_pkg::MC_ERR_BIT];
          s_d.fetch_go  = hwdata[flash_seq_pkg::MC_FETCH_BIT];
          // Go only when permit, space select and unlock already stand
          start_ok = hwdata[flash_seq_pkg::MC_GO_BIT] && !s_q.go && s_q.permit && s_q.pss &&
                     (s_q.ul == flash_seq_pkg::UL_ARMED) && !pwrt_busy;
          if (start_ok && s_q.erase_sel) begin
            if (is_protected(cfg_self_protect, cur_addr)) begin
              s_d.err = 1'b1;
            end else begin
              s_d.go         = 1'b1;
              s_d.op_erase   = 1'b1;
              s_d.seq        = flash_seq_pkg::SEQ_SETUP;
              s_d.flash_addr = {cur_addr[15:flash_seq_pkg::ROW_LSB], 5'h00};
            end
          end else if (start_ok) begin
            if (is_protected(cfg_self_protect, cur_addr)) begin
              s_d.err = 1'b1;
            end else begin
              buf_load     = 1'b1;
              s_d.go       = 1'b1;
              s_d.op_erase = 1'b0;
              if (s_q.addr_low[1:0] != flash_seq_pkg::BLOCK_LAST) begin
                s_d.short_wr = 1'b1;
              end else begin
                s_d.seq        = flash_seq_pkg::SEQ_SETUP;
                s_d.flash_addr = {cur_addr[15:2], 2'b00};
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Short write finishes one cycle after go rises
    if (s_q.short_wr) begin
      s_d.short_wr = 1'b0;
      s_d.go       = 1'b0;
    end
    case (s_q.seq)
      flash_seq_pkg::SEQ_IDLE: begin
      end
      flash_seq_pkg::SEQ_SETUP: begin
        s_d.seq = flash_seq_pkg::SEQ_IGNORE;
      end
      flash_seq_pkg::SEQ_IGNORE: begin
        s_d.seq         = flash_seq_pkg::SEQ_STALL;
        tmr_load        = 1'b1;
        tmr_val         = s_q.op_erase ? flash_seq_pkg::TMR_W'(ERASE_CYCLES) : flash_seq_pkg::TMR_W'(WRITE_CYCLES);
        s_d.erase_start = s_q.op_erase;
        s_d.write_start = !s_q.op_erase;
      end
      flash_seq_pkg::SEQ_STALL: begin
        if (tmr_done) begin
          s_d.seq   = flash_seq_pkg::SEQ_IDLE;
          s_d.go    = 1'b0;
          s_d.done  = 1'b1;
          buf_clear = !s_q.op_erase;
        end
      end
      default: begin
        s_d.seq = flash_seq_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= RESET_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata            = s_q.rdata;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign cpu_stall         = (s_q.seq == flash_seq_pkg::SEQ_STALL);
  assign insn_ignore       = (s_q.seq == flash_seq_pkg::SEQ_IGNORE) ||
                             ((s_q.seq == flash_seq_pkg::SEQ_SETUP) && s_q.op_erase);
  assign flash_erase_start = s_q.erase_start;
  assign flash_write_start = s_q.write_start;
  assign flash_addr        = s_q.flash_addr;
  assign ext_ee_access_allow  = ext_ee_access_req && !cfg_code_protect_data;
  assign ext_prog_write_allow = ext_prog_write_req && !cfg_code_protect_data && !cfg_code_protect_prog;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence erase_begin;
    $rose(s_q.go) && s_q.op_erase;
  endsequence
  sequence long_begin;
    $rose(s_q.go) && !s_q.op_erase && !s_q.short_wr;
  endsequence

  chk_erase_row_align: assert property (flash_erase_start |-> flash_addr[4:0] == 5'h00)
    else $error("erase address not row aligned");
  chk_write_block_align: assert property (flash_write_start |-> flash_addr[1:0] == 2'b00)
    else $error("write address not block aligned");
  chk_go_needs_permit: assert property ($rose(s_q.go) |->
    $past(s_q.permit) && $past(s_q.ul) == flash_seq_pkg::UL_ARMED)
    else $error("go rose without permit or unlock");
  chk_erase_setup_slots: assert property (erase_begin |->
    insn_ignore [*2] ##1 (cpu_stall && flash_erase_start))
    else $error("erase setup slots wrong");
  chk_long_write_slots: assert property (long_begin |->
    !insn_ignore ##1 insn_ignore ##1 (cpu_stall && flash_write_start))
    else $error("long write slots wrong");
  chk_short_go_clear: assert property ($rose(s_q.go) && s_q.short_wr |=> !s_q.go && !cpu_stall)
    else $error("short write go not cleared");
  chk_buffer_reset: assert property ($fell(cpu_stall) && !s_q.op_erase |-> flash_wdata == {56{1'b1}})
    else $error("buffers not reset after long write");
  chk_done_on_finish: assert property ($fell(cpu_stall) |-> s_q.done && !s_q.go)
    else $error("completion did not clear go and set done");
  chk_pwrt_blocks: assert property (pwrt_busy |-> !$rose(s_q.go))
    else $error("start during power-up timer");
  chk_protect_refuse: assert property (flash_write_start |-> !is_protected(cfg_self_protect, flash_addr))
    else $error("write into protected region");
  chk_ext_blocked: assert property (cfg_code_protect_data |-> !ext_ee_access_allow && !ext_prog_write_allow)
    else $error("external access under data protect");

endmodule // flash_self_erase_write_sequencer

/* logic/flash_seq_pkg.sv */
// Shared constants and types for the flash self erase/write sequencer
package flash_seq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 4;
  localparam int ERASE_TIME_NS  = 2000000;
  localparam int WRITE_TIME_NS  = 2000000;
  localparam int PWRT_TIME_NS   = 72000000;
  localparam int ERASE_CYCLES   = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES   = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES    = (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W          = 25;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_DATA_LOW  = 10'h10C;
  localparam logic [9:0] IDX_ADDR_LOW  = 10'h10D;
  localparam logic [9:0] IDX_DATA_HIGH = 10'h10E;
  localparam logic [9:0] IDX_ADDR_HIGH = 10'h10F;
  localparam logic [9:0] IDX_MEM_CTRL  = 10'h18C;
  localparam logic [9:0] IDX_UNLOCK    = 10'h18D;
  localparam logic [9:0] IDX_STATUS    = 10'h18F;
  localparam logic [9:0] IDX_DONE      = 10'h00D;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MC_PSS_BIT    = 7;
  localparam int MC_ERASE_BIT  = 4;
  localparam int MC_ERR_BIT    = 3;
  localparam int MC_PERMIT_BIT = 2;
  localparam int MC_GO_BIT     = 1;
  localparam int MC_FETCH_BIT  = 0;
  localparam int DONE_BIT      = 4;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_PWRT_BIT   = 1;
  localparam int ST_PROT_LSB   = 2;
  localparam int ST_CPP_BIT    = 4;
  localparam int ST_CPD_BIT    = 5;
  localparam int ROW_LSB       = 5;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND = 8'hAA;
  localparam logic [13:0] BUF_ERASED    = 14'h3FFF;
  localparam logic [1:0]  BLOCK_LAST    = 2'h3;
  localparam logic [1:0]  PROT_NONE     = 2'h3;
  localparam logic [1:0]  PROT_SMALL    = 2'h2;
  localparam logic [1:0]  PROT_MID      = 2'h1;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_SETUP  = 2'b01,
    SEQ_IGNORE = 2'b11,
    SEQ_STALL  = 2'b10
  } seq_state_type;

  typedef enum logic [1:0] {
    UL_NONE  = 2'b00,
    UL_FIRST = 2'b01,
    UL_ARMED = 2'b11
  } unlock_state_type;

endpackage

/* logic/flash_word_buffer.sv */
// Four-entry program word buffer collecting a block before a long write
`timescale 1ns/1ns
module flash_word_buffer #(
  parameter int          WORDS  = 4,
  parameter int          WIDTH  = 14,
  parameter logic [13:0] ERASED = flash_seq_pkg::BUF_ERASED
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     load,
  input  wire logic [1:0]               sel,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     clear,
  output logic      [WORDS*WIDTH-1:0]   words
);

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] word;
  } buf_state_type;

  localparam buf_state_type RESET_VALUE = '{word: {WORDS{ERASED[WIDTH-1:0]}}};

  buf_state_type                s_q;
  buf_state_type                s_d;
  logic [WORDS-1:0][WIDTH-1:0]  next_word;

  // ****************************************
  // Per-entry next value
  // ****************************************
  for (genvar i = 0; i < WORDS; i++) begin : g_entry
    assign next_word[i] = clear ? ERASED[WIDTH-1:0] :
                          (load && (sel == 2'(i))) ? wdata : s_q.word[i];
  end

  always_comb begin
    s_d      = s_q;
    s_d.word = next_word;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= RESET_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  assign words = s_q.word;

endmodule // flash_word_buffer

/* tb/fw_master.sv */
// Firmware model: AHB-Lite master issuing register cycles and start sequences
`timescale 1ns/1ns
module fw_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
  end

  // ****************************************
  // Bus cycles, entered just after a rising edge
  // ****************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [2:0] sz = flash_seq_pkg::HSIZE_WORD);
    logic [31:0] r;
    xfer(1'b1, {idx, 2'b00}, d, sz, r);
  endtask

  // Control, unlock pair, then go with the same control bits
  task automatic start(input logic [7:0] ctrl);
    wr(flash_seq_pkg::IDX_MEM_CTRL, {24'h0, ctrl});
    wr(flash_seq_pkg::IDX_UNLOCK, {24'h0, flash_seq_pkg::UNLOCK_FIRST});
    wr(flash_seq_pkg::IDX_UNLOCK, {24'h0, flash_seq_pkg::UNLOCK_SECOND});
    wr(flash_seq_pkg::IDX_MEM_CTRL, {24'h0, ctrl | 8'h02});
  endtask
endmodule // fw_master

/* tb/tb_top.sv */
// Self-checking bench for the flash self erase/write sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int EC = 8;
  localparam int WC = 8;
  localparam int PC = 16;
  typedef struct packed {logic er; logic [15:0] a; logic [55:0] d;} note_type;
  logic hclk = 1'b0, hresetn, hsel, hwrite, hready, hresp, ee_req, pw_req;
  logic [11:0] haddr;
  logic [1:0] htrans, prot;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rs = 32'hA3BA5C50, rv;
  logic cp_p, cp_d, ee_ok, pw_ok, cpu_stall, insn_ignore, er_go, wr_go;
  logic [15:0] faddr;
  logic [55:0] fdata, blk;
  note_type notes[$];
  note_type nt;
  int bad_count = 0, comparisons = 0, cyc = 0;

  wire hreadyout_w;
  always #2 hclk = ~hclk;
  assign hready = hreadyout_w;

  flash_self_erase_write_sequencer #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC), .PWRT_CYCLES(PC))
    flash_self_erase_write_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout_w),
    .hresp(hresp), .cfg_self_protect(prot), .cfg_code_protect_prog(cp_p), .cfg_code_protect_data(cp_d),
    .ext_prog_write_req(pw_req), .ext_ee_access_req(ee_req), .ext_prog_write_allow(pw_ok),
    .ext_ee_access_allow(ee_ok), .cpu_stall(cpu_stall), .insn_ignore(insn_ignore),
    .flash_erase_start(er_go), .flash_write_start(wr_go), .flash_addr(faddr), .flash_wdata(fdata));

  fw_master fw_i (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input string m);
    fw_i.xfer(1'b0, {idx, 2'b00}, 32'h0, flash_seq_pkg::HSIZE_WORD, rv);
    chk(rv, exp, m);
    chk({hresp, hready}, 2'b01, "bus response");
  endtask

  task automatic load(input logic [15:0] a, input logic [13:0] w);
    fw_i.wr(flash_seq_pkg::IDX_ADDR_HIGH, {24'h0, a[15:8]});
    fw_i.wr(flash_seq_pkg::IDX_ADDR_LOW, {24'h0, a[7:0]});
    fw_i.wr(flash_seq_pkg::IDX_DATA_LOW, {24'h0, w[7:0]});
    fw_i.wr(flash_seq_pkg::IDX_DATA_HIGH, {26'h0, w[13:8]});
  endtask

  // Ignore slots after go, then count stall cycles
  task automatic stall(input logic ign0, input int n, input string m);
    int k;
    k = 0;
    #1 chk(insn_ignore, ign0, m);
    @(posedge hclk);
    #1 chk(insn_ignore, 1'b1, m);
    @(posedge hclk);
    #1;
    while (cpu_stall === 1'b1 && k < 100) begin
      k++;
      @(posedge hclk);
      #1;
    end
    chk(k, n, m);
    @(posedge hclk);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Start pulse watcher
  // ****************************************
  always @(posedge hclk) begin
    if (er_go === 1'b1 || wr_go === 1'b1) begin
      if (notes.size() == 0) chk(1, 0, "start without request");
      else begin
        nt = notes.pop_front();
        chk(er_go, nt.er, "start kind");
        chk(faddr, nt.a, "flash address");
        if (!nt.er) chk(fdata, nt.d, "block data");
      end
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  initial begin
    hresetn <= 1'b0;
    prot    <= flash_seq_pkg::PROT_NONE;
    cp_p    <= 1'b0;
    cp_d    <= 1'b0;
    ee_req  <= 1'b0;
    pw_req  <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h00, "control at reset");
    rdchk(flash_seq_pkg::IDX_STATUS, 32'h0E, "status at reset");
    fw_i.start(8'h94);
    rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h94, "go during power-up");
    repeat (PC) @(posedge hclk);
    rdchk(flash_seq_pkg::IDX_STATUS, 32'h0C, "power-up over");
    rdchk(10'h000, 32'h0, "unmapped read");
    $display("test reset done");
    fw_i.wr(flash_seq_pkg::IDX_UNLOCK, 32'h55);
    fw_i.wr(flash_seq_pkg::IDX_ADDR_LOW, 32'h00);
    fw_i.wr(flash_seq_pkg::IDX_UNLOCK, 32'hAA);
    fw_i.wr(flash_seq_pkg::IDX_MEM_CTRL, 32'h96);
    rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h94, "broken unlock");
    fw_i.wr(flash_seq_pkg::IDX_ADDR_LOW, 32'h5A, 3'h0);
    rdchk(flash_seq_pkg::IDX_ADDR_LOW, 32'h00, "byte write ignored");
    fw_i.start(8'h90);
    rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h90, "go without permit");
    $display("test refusals done");
    rs = xs(rs);
    load({4'h0, rs[11:0]}, 14'h0);
    notes.push_back({1'b1, {4'h0, rs[11:5], 5'h00}, 56'h0});
    fw_i.start(8'h94);
    stall(1'b1, EC + 1, "erase timing");
    rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h94, "go after erase");
    rdchk(flash_seq_pkg::IDX_DONE, 32'h10, "done after erase");
    fw_i.wr(flash_seq_pkg::IDX_DONE, 32'h0);
    rdchk(flash_seq_pkg::IDX_DONE, 32'h0, "done cleared");
    $display("test erase done");
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      blk[i*14 +: 14] = rs[13:0];
      load(16'h0100 + 16'(i), rs[13:0]);
      if (i == 3) notes.push_back({1'b0, 16'h0100, blk});
      fw_i.start(8'h84);
      if (i == 3) stall(1'b0, WC + 1, "long write timing");
      else begin
        #1 chk({insn_ignore, cpu_stall}, 2'b00, "short write");
        @(posedge hclk);
        rdchk(flash_seq_pkg::IDX_MEM_CTRL, 32'h84, "go after short write");
      end
    end
    // Only the last word is loaded, so the rest must be erased values
    rs = xs(rs);
    load(16'h0107, rs[13:0]);
    notes.push_back({1'b0, 16'h0104, rs[13:0], {3{flash_seq_pkg::BUF_ERASED}}});
    fw_i.start(8'h84);
    stall(1'b0, WC + 1, "second block");
    $display("test block write done");
    // Protect codes 0 to 2 each cover addresses below 0x0100; code 1 tries an erase
    for (int p = 0; p < 3; p++) begin
      rs = xs(rs);
      prot <= 2'(p);
      load({8'h00, rs[7:2], 2'b11}, rs[13:0]);
      fw_i.start(p == 1 ? 8'h94 : 8'h84);
      repeat (WC + 4) @(posedge hclk);
      rdchk(flash_seq_pkg::IDX_MEM_CTRL, p == 1 ? 32'h9C : 32'h8C, "protected write");
      fw_i.wr(flash_seq_pkg::IDX_MEM_CTRL, 32'h84);
    end
    prot <= flash_seq_pkg::PROT_NONE;
    $display("test protect done");
    for (int i = 0; i < 16; i++) begin
      cp_d   <= i[3];
      cp_p   <= i[2];
      ee_req <= i[1];
      pw_req <= i[0];
      @(posedge hclk);
      #1 chk(pw_ok, i[0] & !i[2] & !i[3], "external program write");
      chk(ee_ok, i[1] & !i[3], "external eeprom access");
      @(posedge hclk);
    end
    chk(notes.size(), 0, "missing starts");
    $display("test code protect done");
    conclude();
  end
endmodule // tb_top
